// *** hw/spims_port.sv ***
// Byte-wide serial port, master or slave, with APB register access.
// Assumes an APB master on clk; serial pins arrive asynchronously and
// the pad logic resolves each pin from its out and oe signals.
//
// Functional notes
// - Master: data write starts clock generator and shifts eight bits out.
// - Master: after a byte, clock stops and done flag sets; irq if enabled.
// - Master never drives slave select by itself; software owns it.
// - Slave with select high: miso released, sck ignored, data loads only.
// - Slave: full byte shifted sets done flag; irq if enabled.
// - Last received byte is kept in a readable receive buffer.
// - Transmit single-buffered, receive double-buffered; unread byte overwritten.
// - Enabled port overrides pin directions per master or slave role.
// - Slave select low activates slave; high makes it passive.
// - Select rising resets slave counter and drops partial bits.
// - Master with select as output: pin is plain output only.
// - Master with select input driven low: become slave, set done flag.
// - Irq only with done flag, irq enable and global enable set.
// - Enable bit gates all transfers in both roles.
// - Bit order bit one sends LSB first, zero MSB first.
// - Master select bit picks role; hardware clears it on mode fault.
// - Polarity bit sets sck idle level and leading edge direction.
// - Master makes sck; both shift registers exchange at once.
// - Phase bit picks sampling on leading or trailing edge.
// - Master sck divides clk by 4,16,64,128 or doubled 2,8,32,64.
// - Done flag clears on irq ack, or status read then data access.
// - Data write during transfer sets collision flag; cleared by status read then data access.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`include "spims_defs.svh"

module spims_port
   import spims_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial pins
   input wire logic sckIn,
   output logic sckOut,
   output logic sckOe,
   input wire logic mosiIn,
   output logic mosiOut,
   output logic mosiOe,
   input wire logic misoIn,
   output logic misoOut,
   output logic misoOe,
   input wire logic ssnIn,
   output logic ssnOut,
   output logic ssnOe,
   // Interrupt request and vector acknowledge
   output logic irq,
   input wire logic irqAck
);

   // ==========================================================
   // Elaboration check
   initial
   begin
      if (ADDR_W < 8)
         $error("ADDR_W must be at least 8");
   end

   // ==========================================================
   // Helper functions
   // Half sck period in clk cycles for a rate code
   function automatic logic [6:0] halfDiv(input logic [1:0] rate,
                                          input logic dbl);
      logic [6:0] h;
      h = `SPIMS_HALF_4;
      unique case ({dbl, rate})
         3'h0: h = `SPIMS_HALF_4;
         3'h1: h = `SPIMS_HALF_16;
         3'h2: h = `SPIMS_HALF_64;
         3'h3: h = `SPIMS_HALF_128;
         3'h4: h = `SPIMS_HALF_2;
         3'h5: h = `SPIMS_HALF_8;
         3'h6: h = `SPIMS_HALF_32;
         3'h7: h = `SPIMS_HALF_64;
      endcase
      return h;
   endfunction

   // Bit that leaves the shift register next
   function automatic logic topBit(input logic [7:0] d, input logic lsb);
      return lsb ? d[0] : d[7];
   endfunction

   // ==========================================================
   // Registers
   logic [7:0] ctrl_r;
   logic dbl_r;
   logic doneFlag_r;
   logic wcolFlag_r;
   logic armDone_r;
   logic armWcol_r;
   logic [6:0] pinCfg_r;
   logic [7:0] rxBuf_r;
   logic [7:0] shift_r;
   logic outBit_r;
   logic sckLvl_r;
   logic [6:0] divCnt_r;
   logic [4:0] edgeCnt_r;
   spims_state_e state_r;
   logic [31:0] prdata_r;
   logic sckS1_r, sckS2_r, sckS3_r;
   logic ssnS1_r, ssnS2_r;
   logic mosiS1_r, mosiS2_r;
   logic misoS1_r, misoS2_r;
   logic [1:0] mSmp_r, mEnd_r;
   logic [7:0] mRx_r;

   // ==========================================================
   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         sckS1_r <= 1'b0;
         sckS2_r <= 1'b0;
         sckS3_r <= 1'b0;
         ssnS1_r <= 1'b1;
         ssnS2_r <= 1'b1;
         mosiS1_r <= 1'b0;
         mosiS2_r <= 1'b0;
         misoS1_r <= 1'b0;
         misoS2_r <= 1'b0;
      end
      else
      begin
         sckS1_r <= sckIn;
         sckS2_r <= sckS1_r;
         sckS3_r <= sckS2_r;
         ssnS1_r <= ssnIn;
         ssnS2_r <= ssnS1_r;
         mosiS1_r <= mosiIn;
         mosiS2_r <= mosiS1_r;
         misoS1_r <= misoIn;
         misoS2_r <= misoS1_r;
      end
   end

   // ==========================================================
   // Decodes
   logic enabled, isMaster, lsbFirst, clock_polarity, clock_phase;
   logic wrAcc, rdAcc, selCtrl, selStat, selData, selPcfg, mapped;
   logic dataWr, dataAcc, statRd;
   logic busy, modeFault, slaveSel, startM, mDoneEv;
   logic mEdge, edgeLead, edgeTrail, sampleEv, setupEv, inBit, doneEv;
   logic [7:0] shiftIn, mRxIn;

   // Power-down bit and enable bit both gate operation
   assign enabled = ctrl_r[`SPIMS_CTL_EN]
                    & ~pinCfg_r[`SPIMS_PC_PWRDN];
   assign isMaster = ctrl_r[`SPIMS_CTL_MST];
   assign lsbFirst = ctrl_r[`SPIMS_CTL_LSB];
   assign clock_polarity = ctrl_r[`SPIMS_CTL_POL];
   assign clock_phase = ctrl_r[`SPIMS_CTL_PHA];

   // Bus decode; access phase is the only cycle with side effects
   assign selCtrl = paddr == ADDR_W'(`SPIMS_OFS_CTRL);
   assign selStat = paddr == ADDR_W'(`SPIMS_OFS_STAT);
   assign selData = paddr == ADDR_W'(`SPIMS_OFS_DATA);
   assign selPcfg = paddr == ADDR_W'(`SPIMS_OFS_PCFG);
   assign mapped = selCtrl | selStat | selData | selPcfg;
   assign wrAcc = psel & penable & pwrite & mapped;
   assign rdAcc = psel & penable & ~pwrite & mapped;
   assign dataWr = wrAcc & selData;
   assign dataAcc = psel & penable & selData;
   assign statRd = rdAcc & selStat;

   // Slave counts as busy only once a bit has moved
   assign busy = (state_r == SPIMS_MRUN)
                 | ((state_r == SPIMS_SRUN) && edgeCnt_r != 5'h0);
   // Select as input pulled low while master: another master took over
   assign modeFault = enabled & isMaster
                      & ~pinCfg_r[`SPIMS_PC_SSDIR] & ~ssnS2_r;
   // Select as output never reaches the serial logic
   assign slaveSel = enabled & ~isMaster & ~ssnS2_r;
   assign startM = dataWr & ~busy & enabled & isMaster & ~modeFault;

   // Edge sources: own divider as master, synced pin as slave
   assign mEdge = (state_r == SPIMS_MRUN) && divCnt_r == 7'h0;
   always_comb
   begin
      if (state_r == SPIMS_MRUN)
      begin
         edgeLead = mEdge & (sckLvl_r == clock_polarity);
         edgeTrail = mEdge & (sckLvl_r != clock_polarity);
         inBit = misoS2_r;
      end
      else if (state_r == SPIMS_SRUN)
      begin
         // Leading edge leaves the idle level set by polarity
         edgeLead = (sckS2_r != sckS3_r) & (sckS3_r == clock_polarity);
         edgeTrail = (sckS2_r != sckS3_r) & (sckS3_r != clock_polarity);
         inBit = mosiS2_r;
      end
      else
      begin
         edgeLead = 1'b0;
         edgeTrail = 1'b0;
         inBit = 1'b0;
      end
   end

   // Phase picks which edge samples and which sets up
   assign sampleEv = clock_phase ? edgeTrail : edgeLead;
   assign setupEv = clock_phase ? edgeLead : edgeTrail;
   assign shiftIn = lsbFirst ? {inBit, shift_r[7:1]}
                             : {shift_r[6:0], inBit};
   assign mRxIn = lsbFirst ? {misoS2_r, mRx_r[7:1]}
                           : {mRx_r[6:0], misoS2_r};
   assign mDoneEv = mEdge && edgeCnt_r == `SPIMS_EDGES - 5'h1;
   assign doneEv = mEnd_r[1]
                   | ((state_r == SPIMS_SRUN) && sampleEv
                      && edgeCnt_r == `SPIMS_BITS - 5'h1);

   // ==========================================================
   // Transfer state machine
   always_ff @(posedge clk)
   begin
      if (!rstn)
         state_r <= SPIMS_IDLE;
      else
      begin
         unique case (state_r)
            SPIMS_IDLE:
               if (slaveSel)
                  state_r <= SPIMS_SRUN;
               else if (startM)
                  state_r <= SPIMS_MRUN;
            SPIMS_MRUN:
               if (!enabled || modeFault || mDoneEv)
                  state_r <= SPIMS_IDLE;
            SPIMS_SRUN:
               if (!slaveSel)
                  state_r <= SPIMS_IDLE;
            default:
               state_r <= SPIMS_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Sck divider and edge counter
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         divCnt_r <= 7'h0;
         edgeCnt_r <= 5'h0;
         sckLvl_r <= 1'b0;
      end
      else if (state_r == SPIMS_MRUN)
      begin
         if (mEdge)
         begin
            divCnt_r <= halfDiv(ctrl_r[1:0], dbl_r) - 7'h1;
            sckLvl_r <= ~sckLvl_r;
            edgeCnt_r <= edgeCnt_r + 5'h1;
         end
         else
            divCnt_r <= divCnt_r - 7'h1;
      end
      else if (state_r == SPIMS_SRUN)
      begin
         sckLvl_r <= clock_polarity;
         if (sampleEv)
            edgeCnt_r <= doneEv ? 5'h0 : edgeCnt_r + 5'h1;
      end
      else
      begin
         // Leaving a role drops the count, so partial bytes vanish
         edgeCnt_r <= 5'h0;
         sckLvl_r <= clock_polarity;
         divCnt_r <= halfDiv(ctrl_r[1:0], dbl_r) - 7'h1;
      end
   end

   // ==========================================================
   // Shift register and outgoing bit
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         shift_r <= 8'h00;
         outBit_r <= 1'b0;
      end
      else if (dataWr && !busy)
      begin
         // Single transmit buffer: the shift register itself
         shift_r <= pwdata[7:0];
         outBit_r <= topBit(pwdata[7:0], lsbFirst);
      end
      else
      begin
         if (sampleEv)
            shift_r <= shiftIn;
         if (setupEv)
            outBit_r <= topBit(shift_r, lsbFirst);
      end
   end

   // ==========================================================
   // Receive buffer; overwritten if software is late
   always_ff @(posedge clk)
   begin
      if (!rstn)
         rxBuf_r <= 8'h00;
      else if (mEnd_r[1])
         rxBuf_r <= mSmp_r[1] ? mRxIn : mRx_r;
      else if (doneEv)
         rxBuf_r <= shiftIn;
   end

   // Miso is two clk late through its synchroniser, so the master
   // takes each bit, and the end of the byte, two cycles on
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         mSmp_r <= 2'h0;
         mEnd_r <= 2'h0;
         mRx_r <= 8'h00;
      end
      else
      begin
         mSmp_r <= {mSmp_r[0], (state_r == SPIMS_MRUN) & sampleEv};
         mEnd_r <= {mEnd_r[0], mDoneEv};
         if (mSmp_r[1])
            mRx_r <= mRxIn;
      end
   end

   // ==========================================================
   // Control register; mode fault beats a same-cycle write
   always_ff @(posedge clk)
   begin
      if (!rstn)
         ctrl_r <= `SPIMS_CTL_RST;
      else
      begin
         if (wrAcc && selCtrl)
            ctrl_r <= pwdata[7:0];
         if (modeFault)
            ctrl_r[`SPIMS_CTL_MST] <= 1'b0;
      end
   end

   // Double-rate bit and pin configuration
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         dbl_r <= 1'b0;
         pinCfg_r <= `SPIMS_PC_RST;
      end
      else
      begin
         if (wrAcc && selStat)
            dbl_r <= pwdata[`SPIMS_STA_X2];
         if (wrAcc && selPcfg)
            pinCfg_r <= pwdata[6:0];
      end
   end

   // ==========================================================
   // Flags; a set in the clearing cycle wins
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         doneFlag_r <= 1'b0;
         wcolFlag_r <= 1'b0;
         armDone_r <= 1'b0;
         armWcol_r <= 1'b0;
      end
      else
      begin
         if (statRd)
         begin
            armDone_r <= doneFlag_r;
            armWcol_r <= wcolFlag_r;
         end
         else if (dataAcc)
         begin
            armDone_r <= 1'b0;
            armWcol_r <= 1'b0;
         end
         if (doneEv || modeFault)
            doneFlag_r <= 1'b1;
         else if (irqAck
                  || (dataAcc && (armDone_r || armWcol_r)))
            doneFlag_r <= 1'b0;
         if (dataWr && busy)
            wcolFlag_r <= 1'b1;
         else if (dataAcc && armWcol_r)
            wcolFlag_r <= 1'b0;
      end
   end

   // Interrupt needs flag, local and global enable
   assign irq = doneFlag_r & ctrl_r[`SPIMS_CTL_IE]
                & pinCfg_r[`SPIMS_PC_GIE];

   // ==========================================================
   // APB read data captured in the setup phase
   always_ff @(posedge clk)
   begin
      if (!rstn)
         prdata_r <= 32'h0;
      else if (psel && !penable)
      begin
         prdata_r <= 32'h0;
         if (selCtrl)
            prdata_r[7:0] <= ctrl_r;
         else if (selStat)
            prdata_r[7:0] <= {doneFlag_r, wcolFlag_r, 5'h00, dbl_r};
         else if (selData)
            prdata_r[7:0] <= rxBuf_r;
         else if (selPcfg)
            prdata_r[6:0] <= pinCfg_r;
      end
   end

   assign prdata = prdata_r;
   // No wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // ==========================================================
   // Pin drivers and direction overrides
   assign sckOut = sckLvl_r;
   assign sckOe = enabled & isMaster & pinCfg_r[`SPIMS_PC_SCKDIR];
   assign mosiOut = outBit_r;
   assign mosiOe = enabled & isMaster & pinCfg_r[`SPIMS_PC_MOSIDIR];
   assign misoOut = outBit_r;
   // Released whenever the slave is deselected, to avoid contention
   assign misoOe = slaveSel & pinCfg_r[`SPIMS_PC_MISODIR];
   // Select is only what software sets; an enabled slave keeps it input
   assign ssnOut = pinCfg_r[`SPIMS_PC_SSVAL];
   assign ssnOe = pinCfg_r[`SPIMS_PC_SSDIR]
                  & ~(enabled & ~isMaster);

endmodule

// *** hw/spims_defs.svh ***
// Offsets, field positions and reset values of the serial port block.
// Assumes a 32-bit APB slave with byte addresses, one register per word.
`ifndef SPIMS_DEFS_SVH
`define SPIMS_DEFS_SVH

// ==========================================================
// Register byte offsets
`define SPIMS_OFS_CTRL 8'h00
`define SPIMS_OFS_STAT 8'h04
`define SPIMS_OFS_DATA 8'h08
`define SPIMS_OFS_PCFG 8'h0c

// ==========================================================
// Control register fields
`define SPIMS_CTL_IE 7
`define SPIMS_CTL_EN 6
`define SPIMS_CTL_LSB 5
`define SPIMS_CTL_MST 4
`define SPIMS_CTL_POL 3
`define SPIMS_CTL_PHA 2
`define SPIMS_CTL_RATE_HI 1
`define SPIMS_CTL_RATE_LO 0
`define SPIMS_CTL_RST 8'h00

// ==========================================================
// Status register fields
`define SPIMS_STA_DONE 7
`define SPIMS_STA_WRITE_COLLISION_FLAG 6
`define SPIMS_STA_X2 0

// ==========================================================
// Pin and system configuration register fields
`define SPIMS_PC_SSDIR 0
`define SPIMS_PC_SSVAL 1
`define SPIMS_PC_MOSIDIR 2
`define SPIMS_PC_SCKDIR 3
`define SPIMS_PC_MISODIR 4
`define SPIMS_PC_PWRDN 5
`define SPIMS_PC_GIE 6
`define SPIMS_PC_RST 7'h22

// ==========================================================
// Timing: sck edges in one byte and half-period counts per rate
`define SPIMS_EDGES 5'h10
`define SPIMS_BITS 5'h08
`define SPIMS_HALF_4 7'h02
`define SPIMS_HALF_16 7'h08
`define SPIMS_HALF_64 7'h20
`define SPIMS_HALF_128 7'h40
`define SPIMS_HALF_2 7'h01
`define SPIMS_HALF_8 7'h04
`define SPIMS_HALF_32 7'h10

`endif

// *** hw/spims_pkg.sv ***
// Types shared by the serial port block.
// Assumes the constants header supplies offsets and field positions.
package spims_pkg;

   // ==========================================================
   // Transfer state, one-hot
   typedef enum logic [2:0]
   {
      SPIMS_IDLE = 3'h1,
      SPIMS_MRUN = 3'h2,
      SPIMS_SRUN = 3'h4
   } spims_state_e;

endpackage

// *** sim/spims_port_sva.sv ***
// Concurrent checks on the top-level ports of the serial port block.
// Assumes one clk domain with synchronous active-low rstn.
`timescale 1ns/1ps
`include "spims_defs.svh"

module spims_port_sva
   import spims_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // Pins and interrupt
   input wire logic ssnIn,
   input wire logic ssnOut,
   input wire logic sckOe,
   input wire logic mosiOe,
   input wire logic misoOe,
   input wire logic irq,
   input wire logic irqAck
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // ==========================================================
   // Access decode shared by the properties
   wire acc = psel && penable;
   wire mapped = paddr <= 8'h0c && paddr[1:0] == 2'h0;
   wire pcW = acc && pwrite && paddr == `SPIMS_OFS_PCFG;
   wire ctW = acc && pwrite && paddr == `SPIMS_OFS_CTRL;

   // ==========================================================
   // Properties
   property p_err_unmapped;
      acc && !mapped |-> pslverr && prdata == 32'h0;
   endproperty
   a_err_unmapped: assert property (p_err_unmapped)
      else $error("unmapped access not refused");
   property p_err_mapped;
      !acc || mapped |-> !pslverr;
   endproperty
   a_err_mapped: assert property (p_err_mapped)
      else $error("error response without cause");
   property p_rd_upper;
      acc && !pwrite |-> prdata[31:8] == 24'h0;
   endproperty
   a_rd_upper: assert property (p_rd_upper)
      else $error("upper read data not zero");
   property p_miso_rel;
      ssnIn [*4] |-> !misoOe;
   endproperty
   a_miso_rel: assert property (p_miso_rel)
      else $error("miso driven while deselected");
   property p_master_miso_in;
      sckOe |-> !misoOe;
   endproperty
   a_master_miso_in: assert property (p_master_miso_in)
      else $error("master drives miso");
   property p_slave_in;
      misoOe |-> !sckOe && !mosiOe;
   endproperty
   a_slave_in: assert property (p_slave_in)
      else $error("slave drives sck or mosi");
   property p_ss_gpo;
      $changed(ssnOut) |-> $past(pcW);
   endproperty
   a_ss_gpo: assert property (p_ss_gpo)
      else $error("select changed without software write");
   property p_irq_gate;
      irq && (pcW && !pwdata[6] || ctW && !pwdata[7]) |=> !irq;
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("irq stays with an enable cleared");
   property p_ack;
      irqAck |=> !irq;
   endproperty
   a_ack: assert property (p_ack)
      else $error("irq stays after vector taken");
   property p_dis;
      ctW && !pwdata[6] |=> (!sckOe && !mosiOe && !misoOe) [*2];
   endproperty
   a_dis: assert property (p_dis)
      else $error("disabled port drives a serial pin");
endmodule

bind spims_port spims_port_sva #(.ADDR_W(ADDR_W)) u_spims_port_sva (
   .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pslverr(pslverr), .ssnIn(ssnIn), .ssnOut(ssnOut), .sckOe(sckOe),
   .mosiOe(mosiOe), .misoOe(misoOe), .irq(irq), .irqAck(irqAck));

// *** sim/spims_peer.sv ***
// Behavioural byte-wide serial slave facing the port in master role.
// Assumes the port drives sck, mosi and the select line.
`timescale 1ns/1ps

module spims_peer
(
   // Serial lines
   input wire logic sck,
   input wire logic mosi,
   input wire logic ssn,
   output logic miso,
   // Mode and data
   input wire logic clock_polarity,
   input wire logic clock_phase,
   input wire logic [7:0] txByte,
   output logic [7:0] rxByte
);
   logic [7:0] sh;

   // ==========================================================
   // Start-up values
   initial
   begin
      miso = 1'b0;
      rxByte = 8'h00;
      sh = 8'h00;
   end

   // Select low loads; phase zero shows the first bit at once
   always @(negedge ssn)
   begin
      sh = txByte;
      if (!clock_phase)
      begin
         miso = sh[7];
         sh = sh << 1;
      end
   end

   // Released line flips, so a stale bit never reads as valid
   always @(posedge ssn)
      miso = ~miso;

   // Sample on one edge, set up on the other; idle peer ignores sck
   always @(sck)
      if (!ssn)
      begin
         if ((sck != clock_polarity) != clock_phase)
            rxByte = {rxByte[6:0], mosi};
         else
         begin
            miso = sh[7];
            sh = sh << 1;
         end
      end
endmodule

// *** sim/spims_port_test.sv ***
// Self-checking bench: APB tasks, a peer slave for master transfers and
// a bit-banged master for slave transfers. Assumes a zero-wait APB slave.
`timescale 1ns/1ps
`include "spims_defs.svh"

module spims_port_test
   import spims_pkg::*;
;
   logic clk, rstn, psel, penable, pwrite, irqAck, perr;
   logic [7:0] paddr, peerTx, peerRx, ctl, got;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, irq, sckOut, sckOe, mosiOut, mosiOe;
   logic misoOut, misoOe, ssnOut, ssnOe, tbSck, tbMosi, tbSsn, peerMiso;
   int failures, compares, n;
   int hTab[8] = '{2, 8, 32, 64, 1, 4, 16, 32};
   wire sckW = sckOe ? sckOut : tbSck;
   wire mosiW = mosiOe ? mosiOut : tbMosi;
   wire misoW = misoOe ? misoOut : peerMiso;
   wire ssnW = ssnOe ? ssnOut : tbSsn;

   spims_port u_spims_port (.clk(clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sckIn(sckW),
      .sckOut(sckOut), .sckOe(sckOe), .mosiIn(mosiW), .mosiOut(mosiOut),
      .mosiOe(mosiOe), .misoIn(misoW), .misoOut(misoOut), .misoOe(misoOe),
      .ssnIn(ssnW), .ssnOut(ssnOut), .ssnOe(ssnOe), .irq(irq),
      .irqAck(irqAck));
   spims_peer u_spims_peer (.sck(sckW), .mosi(mosiW), .ssn(ssnW),
      .miso(peerMiso), .clock_polarity(ctl[3]), .clock_phase(ctl[2]), .txByte(peerTx),
      .rxByte(peerRx));

   // ==========================================================
   // Clock, 5 ns period
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ==========================================================
   // Tasks
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e)
      begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // One transfer, then an idle cycle so psel is never set twice at once
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, 32'(d));
      if (a == `SPIMS_OFS_CTRL)
         ctl = d;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, 32'(e));
   endtask
   // Poll status; the read that sees done also arms its clearing
   task automatic waitDone();
      rd = 32'h0;
      for (int k = 0; k < 600 && rd[7] !== 1'b1; k++)
         apb(1'b0, `SPIMS_OFS_STAT, 32'h0);
   endtask
   // Cycles between two sck toggles, sampled where values are settled
   task automatic halfPer();
      logic s;
      s = sckOut;
      for (n = 0; sckOut === s && n < 300; n++)
         @(negedge clk);
      s = sckOut;
      for (n = 0; sckOut === s && n < 300; n++)
         @(negedge clk);
      @(posedge clk);
   endtask
   // Bench as master, mode 0, sck at clk/12; miso taken before each rise
   task automatic sbyte(input logic [7:0] b, input int nb, input logic sel);
      tbSsn <= !sel;
      got = 8'h00;
      repeat (8) @(posedge clk);
      for (int k = 7; k > 7 - nb; k--)
      begin
         tbMosi <= b[k];
         repeat (6) @(posedge clk);
         got = {got[6:0], misoW};
         tbSck <= 1'b1;
         repeat (6) @(posedge clk);
         tbSck <= 1'b0;
      end
      repeat (6) @(posedge clk);
      tbMosi <= ~tbMosi;
      tbSsn <= 1'b1;
      @(posedge clk);
   endtask
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ==========================================================
   // Watchdog, far beyond the roughly 4.5k cycles the tests need
   initial
   begin
      #200000;
      failures++;
      stop_test();
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      {rstn, psel, penable, pwrite, irqAck, tbSck, tbMosi} = 7'h00;
      {paddr, pwdata, peerTx, ctl} = 56'h0;
      {tbSsn, failures, compares} = 65'h1_0000_0000_0000_0000;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rdc(`SPIMS_OFS_CTRL, `SPIMS_CTL_RST);
      rdc(`SPIMS_OFS_PCFG, {1'b0, `SPIMS_PC_RST});
      rdc(8'h10, 8'h00);
      chk(32'(perr), 32'h1);
      // Power on, select low, but the port left disabled
      wr(`SPIMS_OFS_PCFG, 8'h0d);
      wr(`SPIMS_OFS_CTRL, 8'h10);
      wr(`SPIMS_OFS_DATA, 8'h99);
      repeat (40) @(posedge clk);
      chk(32'(sckOe), 32'h0);
      rdc(`SPIMS_OFS_STAT, 8'h00);
      wr(`SPIMS_OFS_PCFG, 8'h0f);
      // Master: every mode, every rate and both speeds
      for (int i = 0; i < 8; i++)
      begin
         peerTx = 8'h3c + 8'(i);
         wr(`SPIMS_OFS_STAT, {7'h0, i[2]});
         wr(`SPIMS_OFS_CTRL, {4'h5, i[0], i[1], i[1:0]});
         wr(`SPIMS_OFS_PCFG, 8'h0d);
         wr(`SPIMS_OFS_DATA, 8'hc5 ^ 8'(i));
         halfPer();
         chk(32'(n), 32'(hTab[i]));
         waitDone();
         chk(32'(rd[7]), 32'h1);
         chk(32'(sckOut), 32'(ctl[3]));
         chk(32'(peerRx), 32'(8'hc5 ^ 8'(i)));
         rdc(`SPIMS_OFS_DATA, peerTx);
         rdc(`SPIMS_OFS_STAT, {7'h0, i[2]});
         wr(`SPIMS_OFS_PCFG, 8'h0f);
      end
      // LSB first, slowest rate, data written again mid-transfer
      peerTx = 8'h1e;
      wr(`SPIMS_OFS_STAT, 8'h00);
      wr(`SPIMS_OFS_CTRL, 8'h73);
      wr(`SPIMS_OFS_PCFG, 8'h0d);
      wr(`SPIMS_OFS_DATA, 8'hb4);
      wr(`SPIMS_OFS_DATA, 8'hff);
      waitDone();
      chk(32'(rd[7:6]), 32'h3);
      rdc(`SPIMS_OFS_DATA, 8'h78);
      chk(32'(peerRx), 32'h2d);
      rdc(`SPIMS_OFS_STAT, 8'h00);
      wr(`SPIMS_OFS_PCFG, 8'h0f);
      // Interrupt request, global gate, vector acknowledge
      wr(`SPIMS_OFS_CTRL, 8'hd0);
      wr(`SPIMS_OFS_PCFG, 8'h4d);
      wr(`SPIMS_OFS_DATA, 8'h42);
      waitDone();
      chk(32'(irq), 32'h1);
      wr(`SPIMS_OFS_PCFG, 8'h0d);
      chk(32'(irq), 32'h0);
      wr(`SPIMS_OFS_PCFG, 8'h4f);
      chk(32'(irq), 32'h1);
      irqAck <= 1'b1;
      @(posedge clk);
      irqAck <= 1'b0;
      @(posedge clk);
      chk(32'(irq), 32'h0);
      // Mode fault: select as input pulled low by another master
      wr(`SPIMS_OFS_CTRL, 8'h50);
      wr(`SPIMS_OFS_PCFG, 8'h0c);
      tbSsn <= 1'b0;
      repeat (6) @(posedge clk);
      rdc(`SPIMS_OFS_CTRL, 8'h40);
      chk(32'(sckOe), 32'h0);
      waitDone();
      chk(32'(rd[7]), 32'h1);
      rdc(`SPIMS_OFS_DATA, 8'h1e);
      tbSsn <= 1'b1;
      wr(`SPIMS_OFS_CTRL, 8'h50);
      rdc(`SPIMS_OFS_CTRL, 8'h50);
      // Slave: pulses while deselected, full byte, partial then full
      wr(`SPIMS_OFS_CTRL, 8'h40);
      wr(`SPIMS_OFS_PCFG, 8'h10);
      wr(`SPIMS_OFS_DATA, 8'h5a);
      sbyte(8'hff, 8, 1'b0);
      rdc(`SPIMS_OFS_STAT, 8'h00);
      sbyte(8'hc3, 8, 1'b1);
      chk(32'(got), 32'h5a);
      waitDone();
      chk(32'(rd[7]), 32'h1);
      rdc(`SPIMS_OFS_DATA, 8'hc3);
      sbyte(8'hff, 3, 1'b1);
      sbyte(8'h81, 8, 1'b1);
      waitDone();
      rdc(`SPIMS_OFS_DATA, 8'h81);
      stop_test();
   end
endmodule
